// ### dpsr_top.sv
// duty and profile setup register bank for eight solenoid channels
// assumes frames come assembled from a shifter on CLK, one cycle pulse
`timescale 1ns/1ns
`include "dpsr_defs.svh"
module dpsr_top #(
  parameter int N = 8,
  parameter int M = 64
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic FRAME_VALID,
  input wire logic [31:0] FRAME_DATA,
  input wire logic [`DPSR_CHANNELS-1:0] CTRL_MODE,
  input wire logic [`DPSR_CHANNELS*`DPSR_DUTY_RD_W-1:0] PI_DUTY,
  output logic RESP_VALID,
  output logic [31:0] RESP_DATA,
  output logic [`DPSR_CHANNELS-1:0] PWM_OUT,
  output logic [`DPSR_CHANNELS*`DPSR_DUTY_WR_W-1:0] DUTY_WORD,
  output logic [`DPSR_CHANNELS*`DPSR_PROF_W-1:0] PROFILE_CFG
);
  localparam int CH = `DPSR_CHANNELS;

  logic rst_meta_r;
  logic rst_n;
  logic [`DPSR_DUTY_WR_W-1:0] duty_r [CH];
  logic [`DPSR_PROF_W-1:0] prof_r [CH];
  logic resp_valid_nxt;
  logic [31:0] resp_nxt;
  logic [2:0] channel_number_q_r;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decode
  wire dpsr_pkg::dpsr_sel_t sel = FRAME_DATA[`DPSR_SEL_HI:`DPSR_SEL_LO];
  wire dpsr_pkg::dpsr_channel_number_t channel_number = FRAME_DATA[`DPSR_CHANNEL_NUMBER_HI:`DPSR_CHANNEL_NUMBER_LO];
  wire is_wr = FRAME_DATA[`DPSR_RW_BIT];
  wire hit_duty = FRAME_VALID && (sel == `DPSR_SEL_DUTY);
  wire hit_prof = FRAME_VALID && (sel == `DPSR_SEL_PROF);
  wire wr_duty = hit_duty && is_wr;
  wire wr_prof = hit_prof && is_wr;
  wire direct_cur = CTRL_MODE[channel_number] == dpsr_pkg::DPSR_DIRECT;
  wire [`DPSR_DUTY_WR_W-1:0] duty_cur = duty_r[channel_number];
  wire [`DPSR_PROF_W-1:0] prof_cur = prof_r[channel_number];
  wire [`DPSR_DUTY_RD_W-1:0] pi_cur =
    PI_DUTY[channel_number*`DPSR_DUTY_RD_W +: `DPSR_DUTY_RD_W];
  wire [`DPSR_DUTY_WR_W-1:0] duty_q = duty_r[channel_number_q_r];
  wire [`DPSR_PROF_W-1:0] prof_q = prof_r[channel_number_q_r];

  // direct readback hides bits 12:11 of the stored word
  wire [`DPSR_DUTY_RD_W-1:0] duty_masked = {2'b00,
    duty_cur[`DPSR_DUTY_WR_W-1:`DPSR_MASK_HI+1], 2'b00,
    duty_cur[`DPSR_MASK_LO-1:0]};
  wire [`DPSR_DUTY_RD_W-1:0] duty_rd =
    direct_cur ? duty_masked : pi_cur;

  // response carries the contents before this frame's write takes effect
  assign resp_valid_nxt = hit_duty || hit_prof;
  assign resp_nxt = hit_duty ?
    {1'b0, sel, channel_number, 3'b000, duty_rd} :
    hit_prof ? {1'b0, sel, channel_number, prof_cur} :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // storage, one copy per channel
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      for (int i = 0; i < CH; i++) begin
        duty_r[i] <= `DPSR_DUTY_RST;
        prof_r[i] <= `DPSR_PROF_RST;
      end
    end else begin
      if (wr_duty) begin
        // stored regardless of mode; use waits for direct mode
        duty_r[channel_number] <= FRAME_DATA[`DPSR_DUTY_WR_W-1:0];
      end
      if (wr_prof) begin
        prof_r[channel_number] <= FRAME_DATA[`DPSR_PROF_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      RESP_VALID <= 1'b0;
      RESP_DATA <= 32'h0000_0000;
      channel_number_q_r <= 3'h0;
    end else begin
      RESP_VALID <= resp_valid_nxt;
      RESP_DATA <= resp_nxt;
      channel_number_q_r <= channel_number;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel outputs
  for (genvar g = 0; g < CH; g++) begin : g_ch
    assign DUTY_WORD[g*`DPSR_DUTY_WR_W +: `DPSR_DUTY_WR_W] = duty_r[g];
    assign PROFILE_CFG[g*`DPSR_PROF_W +: `DPSR_PROF_W] = prof_r[g];
    dpsr_pwm #(
      .N(N),
      .M(M)
    ) u_pwm (
      .clk(CLK),
      .rst_n(rst_n),
      .direct(CTRL_MODE[g] == dpsr_pkg::DPSR_DIRECT),
      .duty_direct(duty_r[g]),
      .duty_pi(PI_DUTY[g*`DPSR_DUTY_RD_W +: `DPSR_DUTY_RD_W]),
      .pwm_out(PWM_OUT[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_duty_frame;
    hit_duty;
  endsequence
  sequence s_direct_read;
    hit_duty && direct_cur;
  endsequence
  sequence s_current_read;
    hit_duty && !direct_cur;
  endsequence

  AST_DUTY_ECHO: assert property (@(posedge CLK) disable iff (!rst_n)
    s_duty_frame |=> RESP_VALID
      && RESP_DATA[`DPSR_SEL_HI:`DPSR_SEL_LO] == `DPSR_SEL_DUTY
      && RESP_DATA[`DPSR_CHANNEL_NUMBER_HI:`DPSR_CHANNEL_NUMBER_LO] == $past(channel_number))
    else $error("duty response lost selector or channel");
  AST_PROF_ECHO: assert property (@(posedge CLK) disable iff (!rst_n)
    hit_prof |=> RESP_VALID
      && RESP_DATA[`DPSR_SEL_HI:`DPSR_SEL_LO] == `DPSR_SEL_PROF
      && RESP_DATA[`DPSR_CHANNEL_NUMBER_HI:`DPSR_CHANNEL_NUMBER_LO] == $past(channel_number)
      && RESP_DATA[`DPSR_PROF_W-1:0] == $past(prof_cur))
    else $error("profile response wrong");
  AST_RW_ZERO: assert property (@(posedge CLK) disable iff (!rst_n)
    RESP_VALID |-> !RESP_DATA[31])
    else $error("response bit 31 not zero");
  AST_READ_KEEPS: assert property (@(posedge CLK) disable iff (!rst_n)
    (hit_duty && !is_wr) |=> duty_q == $past(duty_cur))
    else $error("duty read altered stored word");
  AST_DUTY_STORE: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_duty |=> duty_q == $past(FRAME_DATA[`DPSR_DUTY_WR_W-1:0]))
    else $error("duty write not stored");
  AST_MASK: assert property (@(posedge CLK) disable iff (!rst_n)
    s_direct_read |=> RESP_DATA[`DPSR_MASK_HI:`DPSR_MASK_LO] == 2'b00
      && RESP_DATA[`DPSR_MASK_LO-1:0] == $past(duty_cur[`DPSR_MASK_LO-1:0]))
    else $error("direct duty readback wrong");
  AST_PI_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    s_current_read |=> RESP_DATA[`DPSR_DUTY_RD_W-1:0] == $past(pi_cur))
    else $error("current-control readback not regulator output");
  AST_PROF_STORE: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_prof |=> prof_q == $past(FRAME_DATA[`DPSR_PROF_W-1:0]))
    else $error("profile write not stored");
  AST_NO_RESP: assert property (@(posedge CLK) disable iff (!rst_n)
    !(hit_duty || hit_prof) |=> !RESP_VALID)
    else $error("response to a frame not for this bank");
endmodule : dpsr_top

// ### dpsr_defs.svh
// constants for the duty and profile setup register bank
// assumes 32-bit command frames arrive already assembled
// Functional notes
// - selector 1000 addresses the duty register of the channel in bits 26:24
// - stored 19-bit duty drives the channel output in direct PWM mode
// - duty writes in current-control mode are stored, used once direct
// - current-control duty read returns the 21-bit regulator output
// - direct-mode duty read returns stored word with bits 11 and 12 zero
// - duty scales against N*32 direct, N*M in current control
// - 100% on-time reachable; oversized duty saturates, never wraps
// - duty responses echo selector and channel number
// - selector 1001 addresses profile setup 1; response echoes code, channel
// - profile setup holds six 4-bit fields, reset zero, fixed positions
`ifndef DPSR_DEFS_SVH
`define DPSR_DEFS_SVH
`define DPSR_RW_BIT 31
`define DPSR_SEL_HI 30
`define DPSR_SEL_LO 27
`define DPSR_CHANNEL_NUMBER_HI 26
`define DPSR_CHANNEL_NUMBER_LO 24
`define DPSR_SEL_DUTY 4'h8
`define DPSR_SEL_PROF 4'h9
`define DPSR_DUTY_WR_W 19
`define DPSR_DUTY_RD_W 21
`define DPSR_PROF_W 24
`define DPSR_DUTY_RST 19'h0
`define DPSR_PROF_RST 24'h0
`define DPSR_DIRECT_DIV 32
`define DPSR_MASK_HI 12
`define DPSR_MASK_LO 11
`define DPSR_CHANNELS 8
`endif

// ### dpsr_pkg.sv
// types shared by the duty and profile setup register bank
// assumes the constants header is included by each user
package dpsr_pkg;
  typedef enum logic {
    DPSR_CURRENT = 1'b0,
    DPSR_DIRECT = 1'b1
  } dpsr_mode_t;
  typedef logic [3:0] dpsr_sel_t;
  typedef logic [2:0] dpsr_channel_number_t;
endpackage : dpsr_pkg

// ### dpsr_pwm.sv
// one channel's PWM generator for the duty register bank
// assumes a synchronous active-low reset already released on CLK
`timescale 1ns/1ns
`include "dpsr_defs.svh"
module dpsr_pwm #(
  parameter int N = 8,
  parameter int M = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic direct,
  input wire logic [`DPSR_DUTY_WR_W-1:0] duty_direct,
  input wire logic [`DPSR_DUTY_RD_W-1:0] duty_pi,
  output logic pwm_out
);
  localparam logic [`DPSR_DUTY_RD_W-1:0] PER_DIRECT =
    `DPSR_DUTY_RD_W'(N * `DPSR_DIRECT_DIV);
  localparam logic [`DPSR_DUTY_RD_W-1:0] PER_CURRENT =
    `DPSR_DUTY_RD_W'(N * M);

  logic [`DPSR_DUTY_RD_W-1:0] cnt_r;
  logic [`DPSR_DUTY_RD_W-1:0] cnt_nxt;
  logic [`DPSR_DUTY_RD_W-1:0] period;
  logic [`DPSR_DUTY_RD_W-1:0] duty_sel;
  logic wrap;
  logic pwm_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // period and duty selection
  assign period = direct ? PER_DIRECT : PER_CURRENT;
  // a stored word is used only while direct, so current-mode writes wait
  assign duty_sel = direct ? {2'b00, duty_direct} : duty_pi;
  // compare >= period - 1 also covers a counter left high by a mode switch
  assign wrap = cnt_r >= period - 1'b1;
  assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;
  assign pwm_nxt = (duty_sel >= period) || (duty_sel > cnt_r);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      pwm_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pwm_out <= pwm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_PWM_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    (duty_sel >= period) ##1 (duty_sel == $past(duty_sel)) |-> pwm_out)
    else $error("duty at or over period did not hold output on");
  AST_PWM_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (duty_sel == '0) |=> !pwm_out)
    else $error("zero duty drove output on");
  AST_PWM_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_r == period - 1'b1) |=> (cnt_r == '0))
    else $error("period counter did not wrap at period end");
endmodule : dpsr_pwm

// ### dpsr_host.sv
// host side of the frame port: hands one command frame per call
// assumes the caller steps on the falling clock edge, one call per edge
`timescale 1ns/1ns
module dpsr_host (
  input wire logic clk,
  output logic valid,
  output logic [31:0] data
);
  initial begin
    valid = 1'b0;
    data = 32'h0;
  end
  // one whole frame per pulse, any order, back to back allowed
  task automatic send(input logic [31:0] f);
    valid = 1'b1;
    data = f;
  endtask : send
  // released lines show the inverse, not a stale copy of the frame
  task automatic idle();
    valid = 1'b0;
    data = ~data;
  endtask : idle
endmodule : dpsr_host

// ### testbench.sv
// self-checking bench for the duty and profile register bank
// assumes the host model drives frames; small N and M keep periods short
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] mode = 8'h00;
  logic [167:0] pi = '0;
  logic fv;
  logic rv;
  logic [31:0] fd;
  logic [31:0] rd;
  logic [7:0] pwm;
  logic [151:0] dw;
  logic [191:0] pc;
  logic [18:0] m_duty [8];
  logic [23:0] m_prof [8];
  logic [31:0] f;
  logic [31:0] er;
  logic ev;
  int bad_count = 0;
  int checks_done = 0;
  int h [8];
  always #5 clk = ~clk;
  dpsr_host u_dpsr_host (.clk(clk), .valid(fv), .data(fd));
  dpsr_top #(.N(1), .M(4)) u_dpsr_top (.CLK(clk), .NRST(nrst),
    .FRAME_VALID(fv), .FRAME_DATA(fd), .CTRL_MODE(mode), .PI_DUTY(pi),
    .RESP_VALID(rv), .RESP_DATA(rd), .PWM_OUT(pwm), .DUTY_WORD(dw),
    .PROFILE_CFG(pc));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [191:0] seen, input logic [191:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // response reflects contents before this frame's own write
  function automatic logic [31:0] exp_resp(input logic [31:0] q);
    logic [2:0] c = q[26:24];
    logic [18:0] d = m_duty[c];
    if (q[30:27] == 4'h9) return {5'h09, c, m_prof[c]};
    return {5'h08, c, 3'h0, mode[c] ? {2'h0, d[18:13], 2'h0, d[10:0]}
      : pi[c*21 +: 21]};
  endfunction : exp_resp
  function automatic logic [191:0] pack(input logic sel);
    logic [191:0] v = '0;
    for (int j = 0; j < 8; j++) begin
      if (sel) v[j*24 +: 24] = m_prof[j];
      else v[j*19 +: 19] = m_duty[j];
    end
    return v;
  endfunction : pack
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
  initial begin
    logic [18:0] vals [4];
    int chs [4];
    vals = '{19'h0, 19'h20, 19'h10, 19'h7ffff};
    chs = '{0, 1, 2, 4};
    void'($urandom(32'hc4fe371b));
    for (int j = 0; j < 8; j++) begin
      m_duty[j] = '0;
      m_prof[j] = '0;
    end
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check(dw, pack(1'b0));
    check(pc, pack(1'b1));
    check({rd, pwm}, '0);
    $display("test reset values done");
    ev = 1'b0;
    for (int i = 0; i <= 300; i++) begin
      @(negedge clk);
      check(rv, ev);
      if (ev) check(rd, er);
      check(dw, pack(1'b0));
      check(pc, pack(1'b1));
      if (i == 300) break;
      f = $urandom;
      case ($urandom % 4)
        0, 1: f[30:27] = 4'h8;
        2: f[30:27] = 4'h9;
        default: ;
      endcase
      mode = 8'($urandom);
      for (int j = 0; j < 8; j++) pi[j*21 +: 21] = 21'($urandom);
      ev = f[30:27] == 4'h8 || f[30:27] == 4'h9;
      er = exp_resp(f);
      if (f[31] && f[30:27] == 4'h8) m_duty[f[26:24]] = f[18:0];
      if (f[31] && f[30:27] == 4'h9) m_prof[f[26:24]] = f[23:0];
      u_dpsr_host.send(f);
    end
    u_dpsr_host.idle();
    $display("test random frames done");
    // reset in mid-run must clear every channel's stored words again
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    for (int j = 0; j < 8; j++) begin
      m_duty[j] = '0;
      m_prof[j] = '0;
    end
    repeat (3) @(negedge clk);
    check(dw, pack(1'b0));
    check(pc, pack(1'b1));
    check({rv, rd}, '0);
    $display("test mid-run reset done");
    mode = 8'hf7;
    pi[3*21 +: 21] = 21'h3;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      u_dpsr_host.send({5'h18, 3'(chs[k]), 5'h0, vals[k]});
    end
    @(negedge clk);
    u_dpsr_host.idle();
    repeat (4) @(negedge clk);
    h = '{default: 0};
    repeat (64) begin
      @(negedge clk);
      for (int j = 0; j < 8; j++) h[j] += int'(pwm[j]);
    end
    check(32'(h[0]), 32'd0);
    check(32'(h[1]), 32'd64);
    check(32'(h[2]), 32'd32);
    check(32'(h[4]), 32'd64);
    check(32'(h[3]), 32'd48);
    $display("test pwm output done");
    summarize();
  end
endmodule : testbench
